//--- rtl/csw_regs.sv
// compare-swap register slice with rom header and bus id quadlets
// assumes a classic wishbone master on clk_i and a same-clock
// eeprom loader that pulses crc_load_i with crc_value_i valid
`timescale 1ns/100ps
`include "csw_defs.svh"

module csw_regs (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // eeprom loader
    input wire logic crc_load_i,
    input wire logic [15:0] crc_value_i,
    // quadlets presented to the link
    output logic [31:0] rom_header_o,
    output logic [31:0] bus_id_o,
    // status
    output logic swap_busy_o,
    output logic irq_o
);

    // ========================================
    // helpers
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a[7:2] == off[7:2]);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        merge = r;
    endfunction

    // ========================================
    // bus handshake
    logic ack_ff;
    logic nxt_ack;
    logic req;
    logic wr_stb;
    logic rd_stb;

    // the access is taken on the edge at which ack rises
    assign req = cyc_i & stb_i;
    assign wr_stb = req & ~ack_ff & we_i;
    assign rd_stb = req & ~ack_ff & ~we_i;

    always_comb begin
        nxt_ack = req & ~ack_ff;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= nxt_ack;
        end
    end

    // ========================================
    // register state
    logic [31:0] cmp_ff;
    logic [31:0] nxt_cmp;
    logic [31:0] data_ff;
    logic [31:0] nxt_data;
    logic swap_complete_flag_ff;
    logic nxt_swap_complete_flag;
    csw_pkg::csw_res_t resource_select_ff;
    csw_pkg::csw_res_t nxt_resource_select;
    logic [31:0] rom_hdr_ff;
    logic [31:0] nxt_rom_hdr;
    logic [31:0] bus_id_ff;
    logic [31:0] nxt_bus_id;
    logic ctrl_wr;
    logic sel_wr;
    logic cmp_ld_wr;
    logic data_ld_wr;
    logic hdr_wr;
    logic int_clr_wr;
    logic int_en_wr;
    logic swap_finish;

    // one strobe per writable offset, each taken once per access
    assign ctrl_wr = wr_stb & hit(adr_i, `CSW_OFF_CTRL);
    // the select field lives in byte lane 0 only
    assign sel_wr = ctrl_wr & sel_i[0];
    assign cmp_ld_wr = wr_stb & hit(adr_i, `CSW_OFF_CMP_LOAD);
    assign data_ld_wr = wr_stb & hit(adr_i, `CSW_OFF_DATA_LOAD);
    assign hdr_wr = wr_stb & hit(adr_i, `CSW_OFF_ROMHDR);
    // status clear and enable fields all sit in byte lane 0
    assign int_clr_wr = wr_stb & hit(adr_i, `CSW_OFF_INT_CLR) & sel_i[0];
    assign int_en_wr = wr_stb & hit(adr_i, `CSW_OFF_INT_EN) & sel_i[0];

    always_comb begin
        nxt_cmp = cmp_ff;
        nxt_data = data_ff;
        nxt_resource_select = resource_select_ff;
        nxt_swap_complete_flag = swap_complete_flag_ff;
        nxt_rom_hdr = rom_hdr_ff;
        // constant quadlet: no write path reaches it
        nxt_bus_id = bus_id_ff;
        // compare and data are read-only at their own offsets
        // and loaded through separate aliases
        if (cmp_ld_wr) begin
            nxt_cmp = merge(cmp_ff, dat_i, sel_i);
        end
        if (data_ld_wr) begin
            nxt_data = merge(data_ff, dat_i, sel_i);
        end
        // bits 30:2 have no storage at all
        if (ctrl_wr) begin
            nxt_swap_complete_flag = 1'b0;
            if (sel_wr) begin
                nxt_resource_select = csw_pkg::csw_res_t'(dat_i[`CSW_SEL_MSB:0]);
            end
        end
        // completion in the same cycle as a write still sets the flag
        if (swap_finish) begin
            nxt_swap_complete_flag = 1'b1;
        end
        if (hdr_wr) begin
            nxt_rom_hdr = merge(rom_hdr_ff, dat_i, sel_i);
        end
        // eeprom load beats a simultaneous host write of the crc
        if (crc_load_i) begin
            nxt_rom_hdr[15:0] = crc_value_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_ff <= `CSW_ZERO32;
            data_ff <= `CSW_ZERO32;
            swap_complete_flag_ff <= 1'b1;
            resource_select_ff <= csw_pkg::RES_BUS_MANAGER_ID;
            rom_hdr_ff <= `CSW_ROMHDR_RST;
            bus_id_ff <= `CSW_BUSID_VAL;
        end else begin
            cmp_ff <= nxt_cmp;
            data_ff <= nxt_data;
            swap_complete_flag_ff <= nxt_swap_complete_flag;
            resource_select_ff <= nxt_resource_select;
            rom_hdr_ff <= nxt_rom_hdr;
            bus_id_ff <= nxt_bus_id;
        end
    end

    // ========================================
    // swap sequencer
    csw_pkg::csw_state_t state_ff;
    csw_pkg::csw_state_t nxt_state;
    csw_pkg::csw_res_t idx_ff;
    csw_pkg::csw_res_t nxt_idx;
    logic mem_rd;
    logic mem_wr;
    logic [31:0] mem_rd_data;
    logic match;

    assign match = (mem_rd_data == cmp_ff);

    // a write while busy lands on the completing cycle, so the flag ends set; with lane 0 on it loads the select; it does not restart
    always_comb begin
        nxt_state = state_ff;
        nxt_idx = idx_ff;
        mem_rd = 1'b0;
        mem_wr = 1'b0;
        swap_finish = 1'b0;
        case (state_ff)
            csw_pkg::SWAP_IDLE: begin
                if (ctrl_wr) begin
                    nxt_idx = sel_wr ? csw_pkg::csw_res_t'(dat_i[`CSW_SEL_MSB:0])
                                     : resource_select_ff;
                    nxt_state = csw_pkg::SWAP_FETCH;
                end
            end
            csw_pkg::SWAP_FETCH: begin
                mem_rd = 1'b1;
                nxt_state = csw_pkg::SWAP_CHECK;
            end
            csw_pkg::SWAP_CHECK: begin
                // resource word arrives one cycle after the fetch
                mem_wr = match;
                swap_finish = 1'b1;
                nxt_state = csw_pkg::SWAP_IDLE;
            end
            default: begin
                nxt_state = csw_pkg::SWAP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= csw_pkg::SWAP_IDLE;
            idx_ff <= csw_pkg::RES_BUS_MANAGER_ID;
        end else begin
            state_ff <= nxt_state;
            idx_ff <= nxt_idx;
        end
    end

    // resources have no bus address; only the sequencer reaches them
    csw_res_mem u_res_mem (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .rd_en_i(mem_rd),
        .wr_en_i(mem_wr),
        .idx_i(idx_ff),
        .wr_data_i(data_ff),
        .rd_data_o(mem_rd_data)
    );

    // ========================================
    // interrupt status
    logic [`CSW_INT_W-1:0] int_sts_ff;
    logic [`CSW_INT_W-1:0] nxt_int_sts;
    logic [`CSW_INT_W-1:0] int_en_ff;
    logic [`CSW_INT_W-1:0] nxt_int_en;
    logic [`CSW_INT_W-1:0] int_evt;
    logic [`CSW_INT_W-1:0] int_clr;
    logic irq_ff;
    logic nxt_irq;

    always_comb begin
        int_evt = '0;
        int_evt[`CSW_INT_DONE_BIT] = swap_finish;
        int_evt[`CSW_INT_MATCH_BIT] = swap_finish & match;
        int_evt[`CSW_INT_CRC_BIT] = crc_load_i;
        int_clr = '0;
        // status is read-only; only the clear register removes bits
        if (int_clr_wr) begin
            int_clr = dat_i[`CSW_INT_W-1:0];
        end
        nxt_int_en = int_en_ff;
        if (int_en_wr) begin
            nxt_int_en = dat_i[`CSW_INT_W-1:0];
        end
        // a new event wins over a clear in the same cycle
        nxt_int_sts = (int_sts_ff & ~int_clr) | int_evt;
        nxt_irq = |(nxt_int_sts & nxt_int_en);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_sts_ff <= '0;
            int_en_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            int_sts_ff <= nxt_int_sts;
            int_en_ff <= nxt_int_en;
            irq_ff <= nxt_irq;
        end
    end

    // ========================================
    // read data
    logic [31:0] dat_ff;
    logic [31:0] nxt_dat;
    logic [31:0] ctrl_val;
    logic busy_ff;
    logic nxt_busy;

    always_comb begin
        ctrl_val = `CSW_ZERO32;
        ctrl_val[`CSW_CTRL_DONE_BIT] = swap_complete_flag_ff;
        ctrl_val[`CSW_SEL_MSB:0] = resource_select_ff;
    end

    // unmapped and write-only offsets read as zero
    // read data is captured at the taking edge and held until the next read
    always_comb begin
        nxt_dat = dat_ff;
        if (rd_stb) begin
            nxt_dat = `CSW_ZERO32;
            if (hit(adr_i, `CSW_OFF_DATA)) begin
                nxt_dat = data_ff;
            end
            if (hit(adr_i, `CSW_OFF_CMP)) begin
                nxt_dat = cmp_ff;
            end
            if (hit(adr_i, `CSW_OFF_CTRL)) begin
                nxt_dat = ctrl_val;
            end
            if (hit(adr_i, `CSW_OFF_ROMHDR)) begin
                nxt_dat = rom_hdr_ff;
            end
            if (hit(adr_i, `CSW_OFF_BUSID)) begin
                nxt_dat = bus_id_ff;
            end
            if (hit(adr_i, `CSW_OFF_CMP_LOAD)) begin
                nxt_dat = cmp_ff;
            end
            if (hit(adr_i, `CSW_OFF_DATA_LOAD)) begin
                nxt_dat = data_ff;
            end
            if (hit(adr_i, `CSW_OFF_INT_STS)) begin
                nxt_dat[`CSW_INT_W-1:0] = int_sts_ff;
            end
            if (hit(adr_i, `CSW_OFF_INT_EN)) begin
                nxt_dat[`CSW_INT_W-1:0] = int_en_ff;
            end
        end
        nxt_busy = (nxt_state != csw_pkg::SWAP_IDLE);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_ff <= `CSW_ZERO32;
            busy_ff <= 1'b0;
        end else begin
            dat_ff <= nxt_dat;
            busy_ff <= nxt_busy;
        end
    end

    // ========================================
    // outputs
    // header goes to the link as rom quadlet 0; validity before
    // link enable is software's duty
    assign rom_header_o = rom_hdr_ff;
    assign bus_id_o = bus_id_ff;
    assign dat_o = dat_ff;
    assign ack_o = ack_ff;
    assign irq_o = irq_ff;
    assign swap_busy_o = busy_ff;

endmodule

//--- include/csw_defs.svh
// constants for the compare-swap and rom header register slice
// assumes a 32-bit classic wishbone slave with byte addresses
//
// Function
// - compare value register, read-only, 32 bits
// - data register holds value written on match
// - done flag bit 31 set on completion, reset 1
// - a control write while idle clears done flag
// - select bits 1:0 pick one of four resources
// - control bits 30:2 read zero, writes ignored
// - rom header presented as first rom quadlet
// - crc field loaded from eeprom when present
// - header upper half resets to zero
// - bus id reads fixed 3133 3934h
// - resources reached only through compare-swap
`ifndef CSW_DEFS_SVH
`define CSW_DEFS_SVH

// ========================================
// register offsets
`define CSW_OFF_DATA 8'h0C
`define CSW_OFF_CMP 8'h10
`define CSW_OFF_CTRL 8'h14
`define CSW_OFF_ROMHDR 8'h18
`define CSW_OFF_BUSID 8'h1C
`define CSW_OFF_CMP_LOAD 8'h40
`define CSW_OFF_DATA_LOAD 8'h44
`define CSW_OFF_INT_STS 8'h48
`define CSW_OFF_INT_CLR 8'h4C
`define CSW_OFF_INT_EN 8'h50

// ========================================
// field positions
`define CSW_CTRL_DONE_BIT 31
`define CSW_SEL_MSB 1
`define CSW_INT_DONE_BIT 0
`define CSW_INT_MATCH_BIT 1
`define CSW_INT_CRC_BIT 2
`define CSW_INT_W 3

// ========================================
// reset values
`define CSW_BUSID_VAL 32'h31333934
`define CSW_ROMHDR_RST 32'h00000000
`define CSW_RES_RST 32'h00000000
`define CSW_ZERO32 32'h00000000

`endif

//--- include/csw_pkg.sv
// types shared by the compare-swap register slice
// assumes nothing of its surroundings
package csw_pkg;

    // ========================================
    // swap sequencer states
    typedef enum logic [1:0] {
        SWAP_IDLE  = 2'b00,
        SWAP_FETCH = 2'b01,
        SWAP_CHECK = 2'b10
    } csw_state_t;

    // ========================================
    // resource indices
    typedef enum logic [1:0] {
        RES_BUS_MANAGER_ID  = 2'b00,
        RES_BANDWIDTH_AVAIL = 2'b01,
        RES_CHANNELS_HI     = 2'b10,
        RES_CHANNELS_LO     = 2'b11
    } csw_res_t;

endpackage

//--- rtl/csw_res_mem.sv
// four-word store for the bus-management resources
// assumes one port, read data registered one cycle after request
`timescale 1ns/100ps
`include "csw_defs.svh"

module csw_res_mem (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // access port
    input wire logic rd_en_i,
    input wire logic wr_en_i,
    input wire csw_pkg::csw_res_t idx_i,
    input wire logic [31:0] wr_data_i,
    output logic [31:0] rd_data_o
);

    // ========================================
    // storage
    logic [31:0] word_ff [4];
    logic [31:0] nxt_word [4];
    logic [31:0] rd_data_ff;
    logic [31:0] nxt_rd_data;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_word
            always_comb begin
                nxt_word[gi] = word_ff[gi];
                if (wr_en_i && (idx_i == csw_pkg::csw_res_t'(gi))) begin
                    nxt_word[gi] = wr_data_i;
                end
            end

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    word_ff[gi] <= `CSW_RES_RST;
                end else begin
                    word_ff[gi] <= nxt_word[gi];
                end
            end
        end
    endgenerate

    // ========================================
    // registered read
    always_comb begin
        nxt_rd_data = rd_data_ff;
        if (rd_en_i) begin
            nxt_rd_data = word_ff[idx_i];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_data_ff <= `CSW_ZERO32;
        end else begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign rd_data_o = rd_data_ff;

endmodule

//--- test/csw_regs_monitor.sv
// checker for the compare-swap register slice
// assumes it is bound to csw_regs and sees only its ports
`timescale 1ns/100ps
`include "csw_defs.svh"

module csw_regs_monitor (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus side
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // loader and link side
    input wire logic crc_load_i,
    input wire logic [15:0] crc_value_i,
    input wire logic [31:0] rom_header_o,
    input wire logic [31:0] bus_id_o,
    input wire logic swap_busy_o,
    input wire logic irq_o
);
    // ========================================
    // helpers
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic take;
    assign take = cyc_i && stb_i && !ack_o;
    sequence swap_run;
        swap_busy_o ##1 swap_busy_o ##1 !swap_busy_o;
    endsequence

    // ========================================
    // assertions
    ack_next_a: assert property (take |=> ack_o)
        else $error("access not acknowledged next cycle");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    swap_start_a: assert property (take && we_i && adr_i == `CSW_OFF_CTRL && !swap_busy_o
        |=> swap_run) else $error("control write did not run a swap");
    busy_len_a: assert property ($rose(swap_busy_o) |-> swap_busy_o[*2] ##1 !swap_busy_o)
        else $error("swap busy not two cycles");
    busid_fix_a: assert property (bus_id_o == `CSW_BUSID_VAL)
        else $error("bus id output wrong");
    busid_read_a: assert property (take && !we_i && adr_i == `CSW_OFF_BUSID
        |=> dat_o == `CSW_BUSID_VAL) else $error("bus id read wrong");
    ctrl_rsvd_a: assert property (take && !we_i && adr_i == `CSW_OFF_CTRL
        |=> dat_o[30:2] == 29'h0) else $error("control reserved bits not zero");
    crc_load_a: assert property (crc_load_i |=> rom_header_o[15:0] == $past(crc_value_i))
        else $error("crc field not loaded");
    hdr_write_a: assert property (take && we_i && adr_i == `CSW_OFF_ROMHDR && sel_i == 4'hF
        && !crc_load_i |=> rom_header_o == $past(dat_i)) else $error("header not written");
    reset_val_a: assert property ($fell(rst_i) |-> !ack_o && !irq_o && !swap_busy_o
        && rom_header_o[31:16] == 16'h0000) else $error("outputs wrong after reset");
endmodule

bind csw_regs csw_regs_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .crc_load_i(crc_load_i), .crc_value_i(crc_value_i),
    .rom_header_o(rom_header_o), .bus_id_o(bus_id_o), .swap_busy_o(swap_busy_o),
    .irq_o(irq_o));

//--- test/csw_regs_tb.sv
// self-checking bench for the compare-swap register slice
// assumes csw_regs with the monitor bound beside it
`timescale 1ns/100ps
`include "csw_defs.svh"

module csw_regs_tb;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, crc_load_i, swap_busy_o, irq_o;
    logic [7:0] adr_i;
    logic [3:0] sel_i, lanes;
    logic [15:0] crc_value_i;
    logic [31:0] dat_i, dat_o, rom_header_o, bus_id_o, q;
    int n_errors, cmp_count;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d;} csw_row_t;
    // reads compare d, writes send it
    csw_row_t rows [18] = '{
        '{1'h0, 8'h14, 32'h80000000}, '{1'h0, 8'h18, 32'h00000000},
        '{1'h0, 8'h1C, 32'h31333934}, '{1'h0, 8'h10, 32'h00000000},
        '{1'h0, 8'h0C, 32'h00000000}, '{1'h0, 8'h80, 32'h00000000},
        '{1'h1, 8'h18, 32'h12345678}, '{1'h0, 8'h18, 32'h12345678},
        '{1'h1, 8'h1C, 32'hFFFFFFFF}, '{1'h0, 8'h1C, 32'h31333934},
        '{1'h1, 8'h10, 32'hDEADBEEF}, '{1'h0, 8'h10, 32'h00000000},
        '{1'h1, 8'h40, 32'hAABBCCDD}, '{1'h0, 8'h10, 32'hAABBCCDD},
        '{1'h1, 8'h44, 32'h00000055}, '{1'h0, 8'h0C, 32'h00000055},
        '{1'h1, 8'h80, 32'hFFFFFFFF}, '{1'h0, 8'h80, 32'h00000000}};

    csw_regs dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .crc_load_i(crc_load_i), .crc_value_i(crc_value_i), .rom_header_o(rom_header_o),
        .bus_id_o(bus_id_o), .swap_busy_o(swap_busy_o), .irq_o(irq_o));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // ========================================
    // tasks
    task automatic close_out;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("[FAIL] %s exp %h got %h", nm, e, g);
            n_errors++;
        end
    endtask

    // one classic cycle; q holds read data taken at the ack edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= lanes;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1) begin
            chk("bus ack", 32'h1, 32'h0);
            close_out;
        end
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    // reserved bits written as ones must not stick
    task automatic swap(input logic [1:0] s);
        int n;
        // with lane 0 off the low bits sent are inverted and must not land
        wb(1'b1, `CSW_OFF_CTRL, {30'h3FFFFFFF, (lanes[0] ? s : ~s)});
        chk("busy", 32'h1, {31'h0, swap_busy_o});
        n = 0;
        do begin
            wb(1'b0, `CSW_OFF_CTRL, 32'h0);
            n++;
        end while (q[31] !== 1'b1 && n < 10);
        chk("ctrl done", {30'h20000000, s}, q);
        if (q[31] !== 1'b1) close_out;
    endtask

    // ========================================
    // sequence
    initial begin
        {cyc_i, stb_i, we_i, crc_load_i} = 4'h0;
        adr_i = 8'h00;
        sel_i = 4'hF;
        lanes = 4'hF;
        dat_i = 32'h0;
        crc_value_i = 16'h0;
        n_errors = 0;
        cmp_count = 0;
        rst_i = 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 18; i++) begin
            wb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk($sformatf("reg %h", rows[i].a), rows[i].d, q);
        end
        // all resources start at zero, so every select matches once
        wb(1'b1, `CSW_OFF_INT_EN, 32'h1);
        wb(1'b1, `CSW_OFF_CMP_LOAD, 32'h0);
        for (int s = 0; s < 4; s++) begin
            wb(1'b1, `CSW_OFF_INT_CLR, 32'h7);
            swap(s[1:0]);
            wb(1'b0, `CSW_OFF_INT_STS, 32'h0);
            chk("match sts", 32'h3, q);
            chk("irq set", 32'h1, {31'h0, irq_o});
        end
        wb(1'b1, `CSW_OFF_INT_CLR, 32'h7);
        wb(1'b0, `CSW_OFF_INT_STS, 32'h0);
        chk("sts clr", 32'h0, q);
        chk("irq clr", 32'h0, {31'h0, irq_o});
        // resource now holds the data value, so the compare misses
        wb(1'b1, `CSW_OFF_INT_EN, 32'h0);
        swap(2'b01);
        wb(1'b0, `CSW_OFF_INT_STS, 32'h0);
        chk("miss sts", 32'h1, q);
        chk("irq masked", 32'h0, {31'h0, irq_o});
        // lane 0 off: select keeps 01 and the swap still hits resource 1
        wb(1'b1, `CSW_OFF_CMP_LOAD, 32'h55);
        wb(1'b1, `CSW_OFF_DATA_LOAD, 32'h66);
        wb(1'b1, `CSW_OFF_INT_CLR, 32'h7);
        lanes = 4'hE;
        swap(2'b01);
        lanes = 4'hF;
        wb(1'b0, `CSW_OFF_INT_STS, 32'h0);
        chk("lane sts", 32'h3, q);
        wb(1'b1, `CSW_OFF_INT_CLR, 32'h7);
        swap(2'b01);
        wb(1'b0, `CSW_OFF_INT_STS, 32'h0);
        chk("lane miss", 32'h1, q);
        @(posedge clk_i);
        crc_load_i <= 1'b1;
        crc_value_i <= 16'hBEEF;
        @(posedge clk_i);
        crc_load_i <= 1'b0;
        wb(1'b0, `CSW_OFF_ROMHDR, 32'h0);
        chk("crc load", 32'h1234BEEF, q);
        chk("rom out", 32'h1234BEEF, rom_header_o);
        // only the top byte lane may change
        lanes = 4'h8;
        wb(1'b1, `CSW_OFF_ROMHDR, 32'hAB000000);
        lanes = 4'hF;
        wb(1'b0, `CSW_OFF_ROMHDR, 32'h0);
        chk("hdr lanes", 32'hAB34BEEF, q);
        // reset in the middle of a swap
        wb(1'b1, `CSW_OFF_CTRL, 32'h2);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, `CSW_OFF_CTRL, 32'h0);
        chk("ctrl rst", 32'h80000000, q);
        wb(1'b0, `CSW_OFF_ROMHDR, 32'h0);
        chk("hdr rst", 32'h0, q);
        chk("busid out", 32'h31333934, bus_id_o);
        close_out;
    end
endmodule
